// ===== include/lodm_defs.svh
// constants of the or / data-move execution block: apb offsets, encodings,
// field positions and reset values; included by the logic and the dv files.
`ifndef LODM_DEFS_SVH
`define LODM_DEFS_SVH

// apb register byte offsets
`define LODM_OFF_INSTR   12'h000
`define LODM_OFF_CTRL    12'h004
`define LODM_OFF_WREG    12'h008
`define LODM_OFF_BANK    12'h00C
`define LODM_OFF_STATUS  12'h010
`define LODM_OFF_PTR0    12'h014
`define LODM_OFF_PTR1    12'h018
`define LODM_OFF_PTR2    12'h01C
`define LODM_OFF_MADDR   12'h020
`define LODM_OFF_MDATA   12'h024

// status and control field positions
`define LODM_ST_ZERO     0
`define LODM_ST_NEG      1
`define LODM_ST_BUSY     8
`define LODM_ST_WAIT2    9
`define LODM_CTRL_EXT    0

// opcode encodings
`define LODM_ENC_OR_LIT  8'h09
`define LODM_ENC_BANK    8'h01
`define LODM_ENC_OR_FILE 6'h04
`define LODM_ENC_MOVE    6'h14
`define LODM_ENC_PTR     8'hEE
`define LODM_ENC_FF_SRC  4'hC
`define LODM_ENC_SECOND  4'hF

// instruction word field positions
`define LODM_BIT_ACCESS  8
`define LODM_BIT_DEST    9

// addressing
`define LODM_IDX_LIMIT   8'h5F
`define LODM_ACC_HIGH    4'hF
`define LODM_ADDR_WREG   12'hFF0
`define LODM_IDX_PTR     2
`define LODM_PTR_COUNT   3
`define LODM_BANK_MASK   8'h0F

// reset values
`define LODM_RST_W       8'h00
`define LODM_RST_BANK    8'h00
`define LODM_RST_PTR     12'h000
`define LODM_RST_EXT     1'b0

`endif

// ===== include/lodm_pkg.sv
// types shared by the or / data-move execution block.
// assumes lodm_defs.svh is on the include path.
package lodm_pkg;

	// decoded operation of the first instruction word
	typedef enum logic [2:0] {
		OP_NOP      = 3'b000,
		OP_OR_LIT   = 3'b001,
		OP_OR_FILE  = 3'b010,
		OP_MOVE     = 3'b011,
		OP_PTR_LOAD = 3'b100,
		OP_FF_MOVE  = 3'b101,
		OP_BANK     = 3'b110
	} lodm_op_t;

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_RUN   = 2'b01,
		ST_WAIT2 = 2'b10
	} lodm_state_t;

endpackage

// ===== include/lodm_mem_if.sv
// data memory port between the execution core and the file memory.
// assumes one clock; read data is combinational from the address.
`timescale 1ns/1ns
`default_nettype none
interface lodm_mem_if #(parameter int AW = 12);
	logic [AW-1:0] addr;
	logic [7:0]    wdata;
	logic          we;
	logic [7:0]    rdata;

	modport ctrl (output addr, output wdata, output we, input rdata);
	modport mem  (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// ===== logic/lodm_addr_gen.sv
// file address former: bank select, access bank and indexed offset.
// assumes all inputs are stable within the quarter-cycle that uses them.
`timescale 1ns/1ns
`default_nettype none
`include "lodm_defs.svh"
module lodm_addr_gen (
	input  wire logic [7:0]  file_sel,
	input  wire logic        access_bit,
	input  wire logic [7:0]  bank_sel,
	input  wire logic [11:0] index_ptr,
	input  wire logic        ext_en,
	output logic      [11:0] file_addr
);

	// a=1 banks by the low bank nibble, a=0 uses access bank or indexed offset
	always_comb begin
		if (access_bit) begin
			file_addr = {bank_sel[3:0], file_sel};
		end else if (file_sel <= `LODM_IDX_LIMIT) begin
			if (ext_en) begin
				file_addr = index_ptr + {4'h0, file_sel};
			end else begin
				file_addr = {4'h0, file_sel};
			end
		end else begin
			file_addr = {`LODM_ACC_HIGH, file_sel}; // upper access half
		end
	end

endmodule // lodm_addr_gen
`default_nettype wire

// ===== logic/lodm_dmem.sv
// byte-wide file memory, asynchronous read, write on the clock.
// assumes the core drives the port through lodm_mem_if; no reset on contents.
`timescale 1ns/1ns
`default_nettype none
module lodm_dmem #(parameter int AW = 12) (
	input  wire logic clk_sys,
	lodm_mem_if.mem   port
);

	logic [7:0] mem_q [0:(1<<AW)-1];

	// write on the edge, read straight from the address
	always_ff @(posedge clk_sys) begin
		if (port.we) begin
			mem_q[port.addr] <= port.wdata;
		end
	end

	assign port.rdata = mem_q[port.addr];

endmodule // lodm_dmem
`default_nettype wire

// ===== logic/lodm_exec.sv
// execution core for the or, pointer-load, move and bank-load instructions,
// with an apb slave that issues instruction words and exposes core state.
// assumes one 10 mhz clock, apb master, words issued by software writes.
//
// Operation
// - the literal-or opcode ors the 8-bit literal into w and writes w in one cycle.
// - the register-or opcode ors w with the addressed file register using f, d and a.
// - a destination bit of 0 writes w, 1 writes the file register, 1 being the default.
// - access bit 0 selects the access bank, 1 forms the address from bank select and f.
// - access bit 0 with extended set on and f at most 95 uses indexed literal offset.
// - or and single move update only n and z, the other three leave all flags alone.
// - the pointer load puts a 12-bit literal in pointer 0..2, high part first, two cycles.
// - the single move copies the file register to the destination in one cycle.
// - the file-to-file move takes two words, 1100 then 1111, and writes in its last cycle.
// - the file-to-file move accepts w as its source or its destination.
// - the bank load writes literal bits 3:0 and forces the upper four bits to zero.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "lodm_defs.svh"
module lodm_exec
	import lodm_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata_ff,
	output logic             pready_ff,
	output logic             pslverr_ff,
	output logic             busy_ff
);

	////////////////////////////////////////////////////////////////////////
	// functions

	// first-word decode; an unknown or 1111-prefixed word is a no-operation
	function automatic lodm_op_t op_decode(input logic [15:0] iw);
		lodm_op_t op;
		op = OP_NOP;
		if (iw[15:8] == `LODM_ENC_OR_LIT) begin
			op = OP_OR_LIT;
		end else if (iw[15:8] == `LODM_ENC_BANK) begin
			op = OP_BANK;
		end else if (iw[15:8] == `LODM_ENC_PTR) begin
			op = OP_PTR_LOAD;
		end else if (iw[15:10] == `LODM_ENC_OR_FILE) begin
			op = OP_OR_FILE;
		end else if (iw[15:10] == `LODM_ENC_MOVE) begin
			op = OP_MOVE;
		end else if (iw[15:12] == `LODM_ENC_FF_SRC) begin
			op = OP_FF_MOVE;
		end
		return op;
	endfunction

	// instructions that need a second word
	function automatic logic two_word(input lodm_op_t op);
		return (op == OP_PTR_LOAD) || (op == OP_FF_MOVE);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// reset release

	logic rst_meta_ff;
	logic rst_sync_ff;

	// async assert, release through two flops
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state

	lodm_state_t state_ff;
	logic [1:0]  q_ff;        // quarter-cycle q1..q4 as 0..3
	logic [15:0] word_ff;     // current instruction word
	lodm_op_t    op_ff;       // op of the first word
	logic        second_ff;   // executing the second word
	logic [7:0]  dat_ff;      // operand read in q2
	logic [7:0]  res_ff;      // result formed in q3
	logic [1:0]  pidx_ff;     // pointer chosen by the first pointer-load word
	logic [7:0]  w_ff;
	logic [7:0]  bank_ff;
	logic [11:0] ptr_ff [0:`LODM_PTR_COUNT-1];
	logic        neg_ff;
	logic        zero_ff;
	logic        ext_en_ff;
	logic [11:0] maddr_ff;

	lodm_mem_if #(.AW(12)) mem_bus ();

	////////////////////////////////////////////////////////////////////////
	// apb decode

	logic apb_acc;
	logic core_reg;
	logic apb_go;
	logic issue;
	logic mapped;

	assign apb_acc  = psel && penable && !pready_ff;
	assign core_reg = (paddr == `LODM_OFF_INSTR) || (paddr == `LODM_OFF_MDATA);
	// core-owned registers wait while an instruction runs, others answer at once
	assign apb_go   = apb_acc && !((state_ff == ST_RUN) && core_reg);
	assign issue    = apb_go && pwrite && (paddr == `LODM_OFF_INSTR);
	assign mapped   = (paddr[1:0] == 2'b00) && (paddr <= `LODM_OFF_MDATA);

	////////////////////////////////////////////////////////////////////////
	// operand address

	logic [11:0] gen_addr;
	logic [11:0] cur_addr;
	logic        is_w_addr;

	lodm_addr_gen u_addr_gen (
		.file_sel   (word_ff[7:0]),
		.access_bit (word_ff[`LODM_BIT_ACCESS]),
		.bank_sel   (bank_ff),
		.index_ptr  (ptr_ff[`LODM_IDX_PTR]),
		.ext_en     (ext_en_ff),
		.file_addr  (gen_addr)
	);

	// file-to-file words carry a full 12-bit address
	always_comb begin
		if (op_ff == OP_FF_MOVE) begin
			cur_addr = word_ff[11:0];
		end else begin
			cur_addr = gen_addr;
		end
	end

	assign is_w_addr = (cur_addr == `LODM_ADDR_WREG);

	////////////////////////////////////////////////////////////////////////
	// sequencer

	logic in_q4;
	logic file_wr;
	logic dest_file;

	assign in_q4     = (state_ff == ST_RUN) && (q_ff == 2'd3);
	assign dest_file = word_ff[`LODM_BIT_DEST];
	// q4 write to the file space: or/move with d=1, or the move's last cycle
	assign file_wr = in_q4 && ((((op_ff == OP_OR_FILE) || (op_ff == OP_MOVE)) && dest_file)
		|| ((op_ff == OP_FF_MOVE) && second_ff));

	// idle / run / wait-for-second-word; a non-1111 word in wait2 starts afresh
	always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			state_ff  <= ST_IDLE;
			q_ff      <= 2'd0;
			word_ff   <= 16'h0000;
			op_ff     <= OP_NOP;
			second_ff <= 1'b0;
			busy_ff   <= 1'b0;
		end else begin
			case (state_ff)
				ST_IDLE, ST_WAIT2: begin
					if (issue) begin
						word_ff  <= pwdata[15:0];
						state_ff <= ST_RUN;
						busy_ff  <= 1'b1;
						q_ff     <= 2'd0;
						if ((state_ff == ST_WAIT2) && (pwdata[15:12] == `LODM_ENC_SECOND)) begin
							second_ff <= 1'b1;
						end else begin
							second_ff <= 1'b0;
							op_ff     <= op_decode(pwdata[15:0]);
						end
					end
				end
				ST_RUN: begin
					q_ff <= 2'(q_ff + 2'd1);
					if (q_ff == 2'd3) begin
						busy_ff <= 1'b0;
						if (!second_ff && two_word(op_ff)) begin
							state_ff <= ST_WAIT2;
						end else begin
							state_ff <= ST_IDLE;
						end
					end
				end
				default: begin
					state_ff <= ST_IDLE;
					busy_ff  <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// datapath: q2 read, q3 process

	// q2: fetch the operand; w stands in for its own file address
	always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			dat_ff <= 8'h00;
		end else if ((state_ff == ST_RUN) && (q_ff == 2'd1)) begin
			dat_ff <= is_w_addr ? w_ff : mem_bus.rdata;
		end
	end

	// q3: form the result; the move's second cycle keeps the source byte
	always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			res_ff <= 8'h00;
		end else if ((state_ff == ST_RUN) && (q_ff == 2'd2)) begin
			case (op_ff)
				OP_OR_LIT:  res_ff <= w_ff | word_ff[7:0];
				OP_OR_FILE: res_ff <= w_ff | dat_ff;
				OP_MOVE:    res_ff <= dat_ff;
				OP_BANK:    res_ff <= word_ff[7:0] & `LODM_BANK_MASK;
				OP_FF_MOVE: res_ff <= second_ff ? res_ff : dat_ff;
				default:    res_ff <= res_ff;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// q4 writes

	// w: literal or, d=0 results, or any file write that names w
	always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			w_ff <= `LODM_RST_W;
		end else if (apb_go && pwrite && (paddr == `LODM_OFF_WREG)) begin
			w_ff <= pwdata[7:0];
		end else if (in_q4 && (op_ff == OP_OR_LIT)) begin
			w_ff <= res_ff;
		end else if (in_q4 && ((op_ff == OP_OR_FILE) || (op_ff == OP_MOVE)) && !dest_file) begin
			w_ff <= res_ff;
		end else if (file_wr && is_w_addr) begin
			w_ff <= res_ff;
		end
	end

	// n and z only from or and single move; other ops leave them alone
	always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			neg_ff  <= 1'b0;
			zero_ff <= 1'b0;
		end else if (in_q4 && ((op_ff == OP_OR_LIT) || (op_ff == OP_OR_FILE)
			|| (op_ff == OP_MOVE))) begin
			neg_ff  <= res_ff[7];
			zero_ff <= (res_ff == 8'h00);
		end
	end

	// bank select: upper nibble forced low by the mask in q3
	always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			bank_ff <= `LODM_RST_BANK;
		end else if (in_q4 && (op_ff == OP_BANK)) begin
			bank_ff <= res_ff;
		end
	end

	// pointer load: high nibble on the first word, low byte on the second;
	// an index of 3 matches no pointer and so changes nothing
	always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			pidx_ff <= 2'd0;
			for (int i = 0; i < `LODM_PTR_COUNT; i++) begin
				ptr_ff[i] <= `LODM_RST_PTR;
			end
		end else if (in_q4 && (op_ff == OP_PTR_LOAD)) begin
			if (!second_ff) begin
				pidx_ff <= word_ff[5:4];
			end
			for (int i = 0; i < `LODM_PTR_COUNT; i++) begin
				if (!second_ff && (word_ff[5:4] == 2'(i))) begin
					ptr_ff[i][11:8] <= word_ff[3:0];
				end else if (second_ff && (pidx_ff == 2'(i))) begin
					ptr_ff[i][7:0] <= word_ff[7:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// memory port: core owns it while running, software otherwise

	always_comb begin
		if (state_ff == ST_RUN) begin
			mem_bus.addr  = cur_addr;
			mem_bus.wdata = res_ff;
			mem_bus.we    = file_wr && !is_w_addr;
		end else begin
			mem_bus.addr  = maddr_ff;
			mem_bus.wdata = pwdata[7:0];
			mem_bus.we    = apb_go && pwrite && (paddr == `LODM_OFF_MDATA);
		end
	end

	lodm_dmem #(.AW(12)) u_dmem (
		.clk_sys (clk_sys),
		.port    (mem_bus.mem)
	);

	////////////////////////////////////////////////////////////////////////
	// apb registers

	// control and memory address written by software
	always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			ext_en_ff <= `LODM_RST_EXT;
			maddr_ff  <= 12'h000;
		end else if (apb_go && pwrite) begin
			if (paddr == `LODM_OFF_CTRL) begin
				ext_en_ff <= pwdata[`LODM_CTRL_EXT];
			end
			if (paddr == `LODM_OFF_MADDR) begin
				maddr_ff <= pwdata[11:0];
			end
		end
	end

	// one wait state minimum; pready drops again after one cycle
	always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else if (apb_go) begin
			pready_ff  <= 1'b1;
			pslverr_ff <= !mapped;
			// a write leaves the last read data standing
			if (!pwrite) begin
				prdata_ff <= 32'h0000_0000;
				case (paddr)
					`LODM_OFF_INSTR:  prdata_ff <= {16'h0000, word_ff};
					`LODM_OFF_CTRL:   prdata_ff <= {31'h0, ext_en_ff};
					`LODM_OFF_WREG:   prdata_ff <= {24'h000000, w_ff};
					`LODM_OFF_BANK:   prdata_ff <= {24'h000000, bank_ff};
					`LODM_OFF_STATUS: begin
						prdata_ff[`LODM_ST_ZERO]  <= zero_ff;
						prdata_ff[`LODM_ST_NEG]   <= neg_ff;
						prdata_ff[`LODM_ST_BUSY]  <= busy_ff;
						prdata_ff[`LODM_ST_WAIT2] <= (state_ff == ST_WAIT2);
					end
					`LODM_OFF_PTR0:   prdata_ff <= {20'h00000, ptr_ff[0]};
					`LODM_OFF_PTR1:   prdata_ff <= {20'h00000, ptr_ff[1]};
					`LODM_OFF_PTR2:   prdata_ff <= {20'h00000, ptr_ff[2]};
					`LODM_OFF_MADDR:  prdata_ff <= {20'h00000, maddr_ff};
					`LODM_OFF_MDATA:  prdata_ff <= {24'h000000, mem_bus.rdata};
					default:          prdata_ff <= 32'h0000_0000;
				endcase
			end
		end else begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

endmodule // lodm_exec
`default_nettype wire

// ===== dv/lodm_exec_props.sv
// checker for the or / data-move execution block: apb answer, busy, read fields.
// assumes it is bound to lodm_exec and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "lodm_defs.svh"
module lodm_exec_props (
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata_ff,
	input wire logic        pready_ff,
	input wire logic        pslverr_ff,
	input wire logic        busy_ff
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	// an access phase still waiting for its answer
	logic acc;
	assign acc = psel && penable && !pready_ff;

	////////////////////////////////////////////////////////////////////////////////
	a_ready_pulse: assert property (pready_ff |=> !pready_ff)
		else $error("ready stood longer than one cycle");
	a_ready_cause: assert property (pready_ff |-> $past(acc))
		else $error("ready without an access phase");
	a_ready_bound: assert property (acc |-> ##[1:6] pready_ff)
		else $error("access phase never answered");
	a_bad_align: assert property (acc && paddr[1:0] != 2'h0 |=> pready_ff && pslverr_ff)
		else $error("misaligned access not refused");
	a_err_data: assert property (pslverr_ff && !pwrite |-> prdata_ff == 32'h0)
		else $error("refused read returned data");
	a_write_keep: assert property (pready_ff && pwrite |-> $stable(prdata_ff))
		else $error("write disturbed read data");
	a_busy_four: assert property ($rose(busy_ff) |-> busy_ff [*4] ##1 !busy_ff)
		else $error("instruction cycle not four clocks");
	a_busy_start: assert property (acc && pwrite && paddr == `LODM_OFF_INSTR
		|-> ##[1:6] busy_ff)
		else $error("issued word did not run");
	a_bank_upper: assert property (pready_ff && !pwrite && paddr == `LODM_OFF_BANK
		|-> prdata_ff[31:4] == 28'h0)
		else $error("bank select upper bits not zero");
	a_ptr_width: assert property (pready_ff && !pwrite
		&& paddr inside {`LODM_OFF_PTR0, `LODM_OFF_PTR1, `LODM_OFF_PTR2}
		|-> prdata_ff[31:12] == 20'h0)
		else $error("pointer wider than twelve bits");
endmodule // lodm_exec_props
`default_nettype wire

// ===== dv/logic_or_and_data_move_exec_test.sv
// self-checking bench for the or / data-move execution block over apb.
// assumes lodm_pkg is compiled first and lodm_defs.svh is on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "lodm_defs.svh"
module logic_or_and_data_move_exec_test;
	logic        clk_sys;
	logic        rstn;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic        busy_ff;
	int          failures;
	int          total_checks;
	int          cycles;
	logic [31:0] rq;
	logic        re;

	lodm_exec uut (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata_ff(prdata_ff),
		.pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .busy_ff(busy_ff));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic final_report;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// one apb transfer; held until ready is sampled, then one idle edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready_ff !== 1'b1) @(posedge clk_sys);
		rq = prdata_ff;
		re = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0);
		check(nm, rq, exp);
	endtask

	// issue a word and wait, bounded, for its instruction cycle to end
	task automatic run(input logic [15:0] w);
		int i;
		apb(1'b1, `LODM_OFF_INSTR, {16'h0, w});
		for (i = 0; i < 20 && busy_ff !== 1'b0; i++) @(posedge clk_sys);
	endtask

	task automatic poke(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, `LODM_OFF_MADDR, {20'h0, a});
		apb(1'b1, `LODM_OFF_MDATA, {24'h0, d});
	endtask

	task automatic peek(input logic [11:0] a, input logic [7:0] exp, input string nm);
		apb(1'b1, `LODM_OFF_MADDR, {20'h0, a});
		rd(`LODM_OFF_MDATA, {24'h0, exp}, nm);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_or_literal;
		rd(`LODM_OFF_WREG, 32'h0, "w reset");
		apb(1'b1, `LODM_OFF_WREG, 32'h9A);
		run(16'h0935);
		rd(`LODM_OFF_WREG, 32'hBF, "w or literal");
		rd(`LODM_OFF_STATUS, 32'h2, "neg flag");
		apb(1'b1, `LODM_OFF_WREG, 32'h0);
		run(16'h0900);
		rd(`LODM_OFF_STATUS, 32'h1, "zero flag");
		run(16'h01A5);
		rd(`LODM_OFF_BANK, 32'h5, "bank nibble");
		rd(`LODM_OFF_STATUS, 32'h1, "bank keeps flags");
		// a second issue while the first still runs is stalled, not lost
		apb(1'b1, `LODM_OFF_INSTR, 32'h0901);
		check("busy after issue", {31'h0, busy_ff}, 32'h1);
		run(16'h0902);
		rd(`LODM_OFF_WREG, 32'h3, "stalled issue");
	endtask

	// bank 5 with access bit 1 reaches 0x512
	task automatic t_or_file;
		poke(12'h512, 8'h13);
		apb(1'b1, `LODM_OFF_WREG, 32'h91);
		run(16'h1112);
		rd(`LODM_OFF_WREG, 32'h93, "or file to w");
		peek(12'h512, 8'h13, "file kept");
		run(16'h1312);
		peek(12'h512, 8'h93, "or file to file");
		rd(`LODM_OFF_STATUS, 32'h2, "or file flags");
	endtask

	task automatic t_move_access;
		poke(12'hF80, 8'h00);
		poke(12'h020, 8'hC4);
		run(16'h5080);
		rd(`LODM_OFF_WREG, 32'h0, "move access high");
		rd(`LODM_OFF_STATUS, 32'h1, "move zero");
		run(16'h5020);
		rd(`LODM_OFF_WREG, 32'hC4, "move access low");
		rd(`LODM_OFF_STATUS, 32'h2, "move neg");
	endtask

	// high part first, status shows the wait for the second word
	task automatic t_pointer;
		int i;
		for (i = 0; i < 3; i++) begin
			run(16'hEE01 | 16'(i << 4));
			rd(`LODM_OFF_STATUS, 32'h202, "pointer first word");
			run(16'hF010 + 16'(i));
			rd(`LODM_OFF_PTR0 + 12'(4 * i), 32'h110 + i, "pointer value");
		end
		rd(`LODM_OFF_STATUS, 32'h2, "pointer keeps flags");
	endtask

	// pointer 2 is 0x112; 0x5F is the last indexed offset, 0x60 is not
	task automatic t_indexed;
		poke(12'h171, 8'h7E);
		poke(12'h05F, 8'h11);
		poke(12'hF60, 8'hC3);
		apb(1'b1, `LODM_OFF_CTRL, 32'h1);
		run(16'h505F);
		rd(`LODM_OFF_WREG, 32'h7E, "indexed offset");
		run(16'h5060);
		rd(`LODM_OFF_WREG, 32'hC3, "above index limit");
		apb(1'b1, `LODM_OFF_CTRL, 32'h0);
	endtask

	task automatic t_ff_move;
		poke(12'h123, 8'h33);
		run(16'hC123);
		run(16'hF456);
		peek(12'h456, 8'h33, "file to file");
		run(16'hC123);
		run(16'hFFF0);
		rd(`LODM_OFF_WREG, 32'h33, "file to w");
		apb(1'b1, `LODM_OFF_WREG, 32'h44);
		run(16'hCFF0);
		run(16'hF124);
		peek(12'h124, 8'h44, "w to file");
		rd(`LODM_OFF_STATUS, 32'h2, "move keeps flags");
		poke(12'h200, 8'h5A);
		run(16'hF200);
		peek(12'h200, 8'h5A, "stray second word");
		rd(`LODM_OFF_WREG, 32'h44, "stray keeps w");
	endtask

	// unmapped read and misaligned write are refused
	task automatic t_errors;
		apb(1'b0, 12'h028, 32'h0);
		check("unmapped error", {31'h0, re}, 32'h1);
		check("unmapped data", rq, 32'h0);
		apb(1'b1, 12'h009, 32'hFF);
		check("misaligned error", {31'h0, re}, 32'h1);
		rd(`LODM_OFF_WREG, 32'h44, "misaligned ignored");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// 100 ns clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// hang guard, far beyond the few hundred cycles the run needs
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end

	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_or_literal();
		t_or_file();
		t_move_access();
		t_pointer();
		t_indexed();
		t_ff_move();
		t_errors();
		final_report();
	end
endmodule // logic_or_and_data_move_exec_test

bind lodm_exec lodm_exec_props u_props (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata_ff(prdata_ff),
	.pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .busy_ff(busy_ff));
`default_nettype wire
